// ==== include/expander_pkg.sv ====
// Purpose: shared constants and types of the port expander core
// Assumes: 50 MHz sampling clock
// Notes: read pointer values 0 and 1 select the input port registers
package expander_pkg;
  // --------------------------------------------------------------------
  // addressing
  // --------------------------------------------------------------------
  localparam logic [4:0] ADDR_FIXED = 5'h1D;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_INPUT0 = 3'h0;
  localparam logic [SEL_W-1:0] SEL_INPUT1 = 3'h1;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int PORT_W = 8;
  localparam int PINS = 16;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 20;
  localparam int ALERT_VALID_DELAY_NS = 4000;
  localparam int ALERT_VALID_DELAY_CYC =
    ALERT_VALID_DELAY_NS / SYS_CLK_PERIOD_NS;
  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ADDR    = 7'h02,
    ST_ADDRACK = 7'h04,
    ST_WRBYTE  = 7'h08,
    ST_WRACK   = 7'h10,
    ST_RDBYTE  = 7'h20,
    ST_RDACK   = 7'h40
  } busState_t;
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [7:0] data;
  } wrReq_t;
  typedef struct packed {
    logic [PINS-1:0] highSideDriver;
    logic [PINS-1:0] lowSideDriver;
  } pinDrive_t;
  // sync reset values: reset pin high, supply good, bus idle high
  localparam logic [5:0] SYNC_CTRL_RST = 6'h3C;
endpackage : expander_pkg

// ==== src/byte_fifo.sv ====
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("byte_fifo: bad DEPTH or WIDTH");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q, rdPtr_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [AW:0] fill = wrPtr_q - rdPtr_q;
  assign inReady = fill != (AW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData = mem[rdPtr_q[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + (AW+1)'(push);
      rdPtr_q <= rdPtr_q + (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// ==== src/i2c_port_expander_core.sv ====
// Purpose: i2c target engine, pin drivers and change alert of a
//   16-pin expander
// Assumes: register file outside on sys_clk, selected by regSel
// Notes: a full write buffer answers a data byte with a not-acknowledge
`timescale 1ns/100ps
module i2c_port_expander_core #(
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // external reset sources
  input wire logic resetPinN,
  input wire logic porHold,
  // i2c bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelect0,
  input wire logic addrSelect1,
  // port pins
  input wire logic [expander_pkg::PINS-1:0] pinIn,
  output expander_pkg::pinDrive_t pinDrive,
  output logic alertOutN,
  output logic alertOe,
  // register file side
  input wire logic [expander_pkg::PINS-1:0] cfgDir,
  input wire logic [expander_pkg::PINS-1:0] outVal,
  output logic [expander_pkg::SEL_W-1:0] regSel,
  input wire logic [7:0] rdData,
  output expander_pkg::wrReq_t wrWord,
  output logic wrValid,
  input wire logic wrReady
);
  import expander_pkg::*;
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("FIFO_DEPTH too small");
    end
  end
  // --------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------
  localparam int SW = 6 + PINS;
  localparam logic [SW-1:0] SYNC_RST = {SYNC_CTRL_RST, {PINS{1'b0}}};
  logic [SW-1:0] sync1_q, sync2_q;
  wire [SW-1:0] rawIn = {resetPinN, sclIn, sdaIn, porHold,
                         addrSelect1, addrSelect0, pinIn} ^ {3'b000,
                         1'b1, 2'b00, {PINS{1'b0}}};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
    end
  end
  wire rstPinS = sync2_q[SW-1];
  wire sclS = sync2_q[SW-2];
  wire sdaS = sync2_q[SW-3];
  wire porOkS = sync2_q[SW-4];
  wire [1:0] addrSelS = sync2_q[PINS+1:PINS];
  wire [PINS-1:0] pinS = sync2_q[PINS-1:0];
  // the reset pin and the supply hold both feed one synchronous reset
  wire rstAll = rst || !rstPinS || !porOkS;
  // --------------------------------------------------------------------
  // bus events
  // --------------------------------------------------------------------
  logic sclPrev_q, sdaPrev_q;
  always_ff @(posedge sys_clk) begin
    if (rstAll) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end
  wire sclRise = sclS && !sclPrev_q;
  wire sclFall = !sclS && sclPrev_q;
  // sda moving while scl high is control, never data
  wire startEvt = sclS && sclPrev_q && sdaPrev_q && !sdaS;
  wire stopEvt = sclS && sclPrev_q && !sdaPrev_q && sdaS;
  // --------------------------------------------------------------------
  // protocol engine
  // --------------------------------------------------------------------
  busState_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic sdaOe_q, sdaOe_d;
  logic isRead_q, isRead_d;
  logic firstByte_q, firstByte_d;
  logic [SEL_W-1:0] ptr_q, ptr_d;
  logic push;
  logic [1:0] portClear;
  wire fifoReady;
  wire byteDone = cnt_q == BYTE_BITS;
  wire [7:0] rxByte = shift_q;
  wire [6:0] ownAddr = {ADDR_FIXED, addrSelS};
  // address taken msb first with direction last
  wire addrHit = rxByte[7:1] == ownAddr &&
                 rxByte[7:1] != GENERAL_CALL;
  wire [SEL_W-1:0] ptrPair = ptr_q ^ SEL_W'(1);
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    sdaOe_d = sdaOe_q;
    isRead_d = isRead_q;
    firstByte_d = firstByte_q;
    ptr_d = ptr_q;
    push = 1'b0;
    portClear = 2'b00;
    if (sclRise) begin
      shift_d = {shift_q[6:0], sdaS};
      cnt_d = cnt_q + 4'h1;
    end
    if (startEvt) begin
      state_d = ST_ADDR;
      cnt_d = '0;
      sdaOe_d = 1'b0;
    end else if (stopEvt) begin
      state_d = ST_IDLE;
      sdaOe_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (sclFall && byteDone) begin
            if (addrHit) begin
              state_d = ST_ADDRACK;
              sdaOe_d = 1'b1;
              isRead_d = rxByte[0];
            end else begin
              // other targets: stay silent until the next start
              state_d = ST_IDLE;
            end
          end
        end
        ST_ADDRACK: begin
          if (sclFall) begin
            cnt_d = '0;
            firstByte_d = 1'b1;
            if (isRead_q) begin
              state_d = ST_RDBYTE;
              tx_d = rdData;
              sdaOe_d = !rdData[7];
            end else begin
              state_d = ST_WRBYTE;
              sdaOe_d = 1'b0;
            end
          end
        end
        ST_WRBYTE: begin
          if (sclFall && byteDone) begin
            state_d = ST_WRACK;
            firstByte_d = 1'b0;
            if (firstByte_q) begin
              ptr_d = rxByte[SEL_W-1:0];
              sdaOe_d = 1'b1;
            end else if (fifoReady) begin
              push = 1'b1;
              ptr_d = ptrPair;
              sdaOe_d = 1'b1;
            end
          end
        end
        ST_WRACK: begin
          if (sclFall) begin
            state_d = ST_WRBYTE;
            cnt_d = '0;
            sdaOe_d = 1'b0;
          end
        end
        ST_RDBYTE: begin
          if (sclFall) begin
            if (byteDone) begin
              state_d = ST_RDACK;
              sdaOe_d = 1'b0;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              sdaOe_d = !tx_q[6];
            end
          end
        end
        ST_RDACK: begin
          if (sclRise) begin
            // clear after the rising edge of the ack or nack clock
            if (ptr_q == SEL_INPUT0) begin
              portClear[0] = 1'b1;
            end
            if (ptr_q == SEL_INPUT1) begin
              portClear[1] = 1'b1;
            end
            ptr_d = ptrPair;
            isRead_d = !sdaS;
          end
          if (sclFall) begin
            cnt_d = '0;
            if (isRead_q) begin
              state_d = ST_RDBYTE;
              tx_d = rdData;
              sdaOe_d = !rdData[7];
            end else begin
              state_d = ST_IDLE;
              sdaOe_d = 1'b0;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          sdaOe_d = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rstAll) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      shift_q <= '0;
      tx_q <= '0;
      sdaOe_q <= 1'b0;
      isRead_q <= 1'b0;
      firstByte_q <= 1'b0;
      ptr_q <= SEL_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      sdaOe_q <= sdaOe_d;
      isRead_q <= isRead_d;
      firstByte_q <= firstByte_d;
      ptr_q <= ptr_d;
    end
  end
  assign sdaOe = sdaOe_q;
  assign sdaOut = 1'b0;
  assign regSel = ptr_q;
  // --------------------------------------------------------------------
  // write buffer toward the register file
  // --------------------------------------------------------------------
  wrReq_t pushWord;
  assign pushWord = '{sel: ptr_q, data: rxByte};
  byte_fifo #(
    .WIDTH($bits(wrReq_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rstAll),
    .inValid(push),
    .inData(pushWord),
    .inReady(fifoReady),
    .outValid(wrValid),
    .outData(wrWord),
    .outReady(wrReady)
  );
  // --------------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------------
  pinDrive_t drive_q;
  // config bit high means input: both transistors off
  wire [PINS-1:0] isOut = ~cfgDir;
  always_ff @(posedge sys_clk) begin
    if (rstAll) begin
      drive_q <= '0;
    end else begin
      drive_q.highSideDriver <= isOut & outVal;
      drive_q.lowSideDriver <= isOut & ~outVal;
    end
  end
  assign pinDrive = drive_q;
  // --------------------------------------------------------------------
  // change alert
  // --------------------------------------------------------------------
  // reference is the level last handed to the host; it is not followed
  // while a pin is an output, so turning it back may raise an alert
  logic [PINS-1:0] ref_q;
  logic alertOe_q;
  wire [PINS-1:0] diff = (pinS ^ ref_q) & cfgDir;
  wire pending = |diff;
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_port
      always_ff @(posedge sys_clk) begin
        if (rstAll) begin
          ref_q[gp*PORT_W +: PORT_W] <= pinS[gp*PORT_W +: PORT_W];
        end else if (portClear[gp]) begin
          ref_q[gp*PORT_W +: PORT_W] <=
            pinS[gp*PORT_W +: PORT_W];
        end
      end
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (rstAll) begin
      alertOe_q <= 1'b0;
    end else begin
      alertOe_q <= pending;
    end
  end
  assign alertOe = alertOe_q;
  assign alertOutN = 1'b0;
  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  localparam int AlertMax = ALERT_VALID_DELAY_CYC;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_inputs: assert property (rstAll |=> drive_q == '0)
    else $error("pin driven after reset");
  a_reset_idle: assert property (rstAll |=> state_q == ST_IDLE
      && !sdaOe_q && !alertOe_q)
    else $error("bus engine not idle after reset");
  a_input_hiz: assert property (!rstAll ##1 !rstAll |->
      ((drive_q.highSideDriver | drive_q.lowSideDriver)
      & $past(cfgDir)) == '0)
    else $error("input pin driven");
  a_output_one: assert property (!rstAll ##1 !rstAll |->
      drive_q.highSideDriver == ($past(isOut) & $past(outVal))
      && (drive_q.highSideDriver ^ drive_q.lowSideDriver) == $past(isOut))
    else $error("output pin drive wrong");
  a_alert_raise: assert property (disable iff (rstAll)
      pending |-> ##[1:AlertMax] alertOe_q)
    else $error("alert late");
  a_alert_drop: assert property (disable iff (rstAll)
      !pending [*2] |-> !alertOe_q)
    else $error("alert not released");
  a_read_clear0: assert property (disable iff (rstAll)
      state_q == ST_RDACK && sclRise && ptr_q == SEL_INPUT0
      |=> ref_q[PORT_W-1:0] == $past(pinS[PORT_W-1:0]))
    else $error("port 0 read did not clear");
  a_port_isolate: assert property (disable iff (rstAll)
      portClear == 2'b10 |=> $stable(ref_q[PORT_W-1:0]))
    else $error("port 1 read cleared port 0");
  a_out_no_alert: assert property (cfgDir == '0 |=> !alertOe_q)
    else $error("output pin raised alert");
  a_gencall: assert property (disable iff (rstAll)
      state_q == ST_ADDR && sclFall && byteDone && !startEvt
      && !stopEvt && rxByte[7:1] == GENERAL_CALL
      |=> state_q == ST_IDLE && !sdaOe_q)
    else $error("general call answered");
  a_ack_low: assert property (disable iff (rstAll)
      state_q == ST_ADDRACK |-> sdaOe_q)
    else $error("address ack not held low");
  a_stop_idle: assert property (disable iff (rstAll)
      stopEvt && !startEvt |=> state_q == ST_IDLE && !sdaOe_q)
    else $error("stop not honoured");
  a_nack_free: assert property (disable iff (rstAll)
      state_q == ST_IDLE |-> !sdaOe_q)
    else $error("sda held while idle");
  c_write: cover property (push);
  c_read_clear: cover property (portClear != 2'b00);
  c_alert: cover property (!alertOe_q ##1 alertOe_q);
  c_read_nack: cover property (state_q == ST_RDACK ##1 state_q == ST_IDLE);
endmodule : i2c_port_expander_core

// ==== verification/i2c_master_model.sv ====
// Purpose: behavioural i2c bus master facing the expander core
// Assumes: open-drain bus with pull-ups, 160 ns link clock period
// Notes: clock stands high between frames; low phase longer than high,
//   which leaves the target's answer time to settle before the rise
`timescale 1ns/100ps
module i2c_master_model (
  // resolved data line
  input wire logic sdaBus,
  // driven lines, 1 = released
  output logic scl,
  output logic sdaDrv
);
  // ------------------------------------------------------------------
  // bit and frame tasks
  // ------------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // 110 ns low, 50 ns high; data moves only while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    #50 sdaDrv = b;
    #60 scl = 1'b1;
    #40 s = sdaBus;
    #10 scl = 1'b0;
  endtask : clk_bit

  // the idle branch shifts phase off the sampling clock's edges
  task automatic start_cond();
    if (scl === 1'b0) begin
      #50 sdaDrv = 1'b1;
      #60 scl = 1'b1;
    end else begin
      #3;
    end
    #60 sdaDrv = 1'b0;
    #60 scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #50 sdaDrv = 1'b0;
    #60 scl = 1'b1;
    #60 sdaDrv = 1'b1;
    #100;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // last byte is answered high so the target lets go of the line
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i]);
    end
    clk_bit(last, s);
  endtask : recv_byte
endmodule : i2c_master_model

// ==== verification/i2c_port_expander_core_tb.sv ====
// Purpose: self-checking bench of the port expander core
// Assumes: 50 MHz sys_clk, master model on a 160 ns link clock
// Notes: input port registers modelled here; writes stall to fill fifo
`timescale 1ns/100ps
module i2c_port_expander_core_tb;
  import expander_pkg::*;
  typedef struct packed {
    logic [PINS-1:0] dir;
    logic [PINS-1:0] val;
    pinDrive_t drv;
  } row_t;
  // upper address bits of this expander, two select pins below them
  localparam logic [4:0] DEV_HI = 5'h1D;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic resetPinN = 1'b1;
  logic porHold = 1'b0;
  logic addrSelect0 = 1'b0;
  logic addrSelect1 = 1'b0;
  logic [PINS-1:0] pinIn = 16'h00F0;
  logic [PINS-1:0] cfgDir = 16'h0000;
  logic [PINS-1:0] outVal = 16'hFFFF;
  logic [7:0] rdData = 8'h00;
  logic wrReady = 1'b0;
  logic scl, sdaDrv, sdaBus, sdaOut, sdaOe, alertOutN, alertOe, wrValid;
  logic ack;
  logic [7:0] rd;
  logic [SEL_W-1:0] regSel;
  pinDrive_t pinDrive;
  wrReq_t wrWord;
  int fails = 0;
  int checkCount = 0;
  row_t rows [4] = '{
    '{16'hFFFF, 16'h1234, 32'h0000_0000},
    '{16'h0000, 16'hA5C3, 32'hA5C3_5A3C},
    '{16'h00FF, 16'hFFFF, 32'hFF00_0000},
    '{16'hF0F0, 16'h3C3C, 32'h0C0C_0303}
  };

  always #10 sys_clk = ~sys_clk;
  assign sdaBus = sdaDrv & (sdaOe ? sdaOut : 1'b1);
  always @(posedge sys_clk) begin
    rdData <= (regSel == SEL_INPUT1) ? pinIn[15:8] : pinIn[7:0];
  end

  i2c_port_expander_core #(.FIFO_DEPTH(8)) i_dut (
    .sys_clk(sys_clk), .rst(rst),
    .resetPinN(resetPinN), .porHold(porHold),
    .sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelect0(addrSelect0), .addrSelect1(addrSelect1),
    .pinIn(pinIn), .pinDrive(pinDrive),
    .alertOutN(alertOutN), .alertOe(alertOe),
    .cfgDir(cfgDir), .outVal(outVal), .regSel(regSel), .rdData(rdData),
    .wrWord(wrWord), .wrValid(wrValid), .wrReady(wrReady)
  );
  i2c_master_model i_master (.sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // which 0 watches the alert, 1 the write queue; bound covers 5 us
  task automatic wait_sig(input int which, input logic exp);
    int n;
    n = 0;
    while (((which == 0) ? alertOe : wrValid) !== exp && n < 250) begin
      @(negedge sys_clk);
      n++;
    end
    check((which == 0) ? alertOe : wrValid, exp);
    if (n == 250 && ((which == 0) ? alertOe : wrValid) !== exp) begin
      tally_and_finish();
    end
  endtask : wait_sig

  function automatic logic [7:0] dev(input logic rw);
    return {DEV_HI, addrSelect1, addrSelect0, rw};
  endfunction : dev

  task automatic set_ptr(input logic [7:0] ptr);
    i_master.start_cond();
    i_master.send_byte(dev(1'b0), ack);
    i_master.send_byte(ptr, ack);
  endtask : set_ptr

  task automatic read_one(input logic [7:0] ptr, output logic [7:0] d);
    set_ptr(ptr);
    i_master.start_cond();
    i_master.send_byte(dev(1'b1), ack);
    i_master.recv_byte(1'b1, d);
    i_master.stop_cond();
  endtask : read_one

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    @(negedge sys_clk);
    check(pinDrive, 32'h0);
    check({sdaOe, alertOe, wrValid, regSel}, 32'h0);
    check({sdaOut, alertOutN}, 32'h0);
    @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge sys_clk);
      cfgDir <= rows[i].dir;
      outVal <= rows[i].val;
      repeat (2) @(negedge sys_clk);
      check(pinDrive, rows[i].drv);
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      if (s == 0) resetPinN <= 1'b0;
      else porHold <= 1'b1;
      repeat (6) @(negedge sys_clk);
      check(pinDrive, 32'h0);
      @(posedge sys_clk);
      resetPinN <= 1'b1;
      porHold <= 1'b0;
      repeat (6) @(negedge sys_clk);
      check(pinDrive, 32'h0C0C_0303);
    end
    @(posedge sys_clk);
    cfgDir <= 16'hFFFF;
    for (int a = 0; a < 4; a++) begin
      @(posedge sys_clk);
      {addrSelect1, addrSelect0} <= a[1:0];
      repeat (4) @(posedge sys_clk);
      i_master.start_cond();
      i_master.send_byte(dev(1'b0), ack);
      check(ack, 1'b1);
      i_master.stop_cond();
    end
    // fill with the drain side stalled; the ninth data byte is refused
    set_ptr(8'h02);
    for (int i = 0; i < 9; i++) begin
      i_master.send_byte(8'(8'h10 + i), ack);
      check(ack, i < 8);
    end
    i_master.stop_cond();
    for (int i = 0; i < 8; i++) begin
      wait_sig(1, 1'b1);
      check(wrWord, {2'h1, i[0], 8'(8'h10 + i)});
      @(posedge sys_clk);
      wrReady <= 1'b1;
      @(posedge sys_clk);
      wrReady <= 1'b0;
      @(negedge sys_clk);
    end
    check(wrValid, 1'b0);
    check(alertOe, 1'b0);
    @(posedge sys_clk);
    pinIn <= 16'h00F8;
    wait_sig(0, 1'b1);
    i_master.start_cond();
    i_master.send_byte(8'hAB, ack);
    check(ack, 1'b0);
    i_master.start_cond();
    i_master.send_byte(8'h00, ack);
    check(ack, 1'b0);
    i_master.stop_cond();
    check(alertOe, 1'b1);
    @(posedge sys_clk);
    pinIn <= 16'h00F0;
    wait_sig(0, 1'b0);
    @(posedge sys_clk);
    pinIn <= 16'h04F0;
    wait_sig(0, 1'b1);
    read_one(8'h00, rd);
    check(rd, 8'hF0);
    check(sdaOe, 1'b0);
    repeat (10) @(negedge sys_clk);
    check(alertOe, 1'b1);
    read_one(8'h01, rd);
    check(rd, 8'h04);
    wait_sig(0, 1'b0);
    set_ptr(8'h02);
    i_master.stop_cond();
    @(posedge sys_clk);
    cfgDir <= 16'hFFF7;
    pinIn <= 16'h04F8;
    repeat (10) @(negedge sys_clk);
    check(alertOe, 1'b0);
    @(posedge sys_clk);
    cfgDir <= 16'hFFFF;
    wait_sig(0, 1'b1);
    tally_and_finish();
  end
endmodule : i2c_port_expander_core_tb
